// File: verilog/fcl_params.svh
// Constants for the flash command host controller.
`ifndef FCL_PARAMS_SVH
`define FCL_PARAMS_SVH
`define FCL_CMD_READ_ARRAY   8'hff
`define FCL_CMD_READ_ID      8'h90
`define FCL_CMD_READ_QUERY   8'h98
`define FCL_CMD_READ_STATUS  8'h70
`define FCL_CMD_CLEAR_STATUS 8'h50
`define FCL_CMD_ERASE_SETUP  8'h20
`define FCL_CMD_CHIP_ERASE   8'h30
`define FCL_CMD_CONFIRM      8'hd0
`define FCL_CMD_PROGRAM      8'h40
`define FCL_CMD_PROGRAM_ALT  8'h10
`define FCL_CMD_PAGE_PROGRAM 8'he8
`define FCL_CMD_SUSPEND      8'hb0
`define FCL_CMD_LOCK_SETUP   8'h60
`define FCL_CMD_SET_LOCK     8'h01
`define FCL_CMD_LOCK_DOWN    8'h2f
`define FCL_CMD_PART_CONFIG  8'h04
`define FCL_ID_MAKER_OFS     16'h0000
`define FCL_ID_PART_OFS      16'h0001
`define FCL_ID_LOCK_OFS      22'h000002
`define FCL_ID_CONFIG_OFS    16'h0006
`define FCL_REG_CTRL         12'h000
`define FCL_REG_ADDR         12'h004
`define FCL_REG_DATA         12'h008
`define FCL_REG_STATUS       12'h00c
`define FCL_REG_RDATA        12'h010
`define FCL_CTRL_GO_BIT      31
`define FCL_CTRL_READ_BIT    30
`define FCL_CTRL_SECOND_BIT  29
`define FCL_CTRL_PAGE_LSB    16
`define FCL_CTRL_OP_LSB      8
`define FCL_CTRL_PROTECT_BIT 1
`define FCL_CTRL_RESET_BIT   0
`define FCL_PHASE_CYCLES     4'd3
`define FCL_SAMPLE_CYCLE     4'd2
`endif

// File: verilog/fcl_pkg.sv
// Types for the flash command host controller.
`default_nettype none
package fcl_pkg;
   typedef enum logic [2:0] {
      FCL_IDLE  = 3'b000,
      FCL_CMD   = 3'b001,
      FCL_ARG   = 3'b010,
      FCL_PAGE  = 3'b011,
      FCL_CONF  = 3'b100,
      FCL_READ  = 3'b101
   } fcl_state_t;
endpackage
`default_nettype wire

// File: verilog/fcl_host.sv
// APB-driven host controller issuing command cycles to a partitioned flash.
//
// Function
// R01: Device runs erase or program in one partition only, never queued.
// R02: Device keeps one status word per partition.
// R03: Host drives an address inside the target block on every cycle.
// R04: Host repeats the first-cycle address on the second cycle.
// R05: FFH array reads, 90H identifier reads, 98H query reads.
// R06: 70H selects status reads; 50H clears status error flags.
// R07: Block erase is 20H then D0H inside the block.
// R08: Chip erase is 30H then D0H; it cannot be suspended.
// R09: Program setup is 40H or 10H, then address and word.
// R10: Device latches data on the first rising strobe edge.
// R11: Page program: E8H, count minus one, address-data pairs, confirm.
// R12: B0H suspends and D0H resumes a partition's operation.
// R13: Host resumes a suspended program before a suspended erase; the host sends suspend and resume in software's order.
// R14: Lock setup 60H; then 01H lock, D0H unlock, 2FH lock-down.
// R15: Configuration is 60H then 04H, code on low address lines.
// R16: Device refuses locked-block alteration; needs reset input high.
// R17: Identifier offsets 0000H maker, 0001H part, 0006H configuration.
// R18: Block base plus 2 gives lock bit 0, lock-down bit 1.
// R19: Identifier upper address depends on the partition that got 90H.
// R20: Reset puts every block in locked, not locked-down state.
// R21: Lock and lock-down transitions; locked-down blocks ignore commands.
// R22: Protect high lets clear lock unlock even locked-down blocks.
// R23: Protect rising moves locked-down blocks per their previous state.
// R24: Protect falling relocks lock-down-disabled blocks.
// R25: Other partitions accept only allowed operations during busy ones.
// R26: Host never drives output enable and write strobe low together.
`include "fcl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module fcl_host (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic      [21:0] o_flash_addr,
   input  wire logic [15:0] i_flash_dq,
   output logic      [15:0] o_flash_dq,
   output logic             o_flash_dq_oe,
   output logic             o_flash_die_select_n,
   output logic             o_flash_we_n,
   output logic             o_flash_oe_n,
   output logic             o_flash_reset_n,
   output logic             o_flash_protect_n
);
   import fcl_pkg::*;

   // ------------------------------------------------------------------
   // State.
   // ------------------------------------------------------------------
   typedef struct packed {
      fcl_state_t  state;
      logic [3:0]  phase;
      logic        busy;
      logic        second;
      logic [7:0]  op;
      logic [7:0]  arg;
      logic [4:0]  page_left;
      logic [21:0] addr;
      logic [15:0] data;
      logic [15:0] rdata;
      logic        protect;
      logic        dev_reset;
      logic [21:0] pin_addr;
      logic [15:0] pin_dq;
      logic        pin_oe;
      logic        pin_cs_n;
      logic        pin_we_n;
      logic        pin_rd_n;
   } fcl_regs_t;

   fcl_regs_t r;
   fcl_regs_t next_r;
   logic      wr_acc;
   logic      rd_acc;

   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && i_penable && !i_pwrite;
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;

   // ------------------------------------------------------------------
   // Register reads.
   // ------------------------------------------------------------------
   always_comb begin
      o_prdata = 32'h0000_0000;
      unique case (i_paddr)
         `FCL_REG_CTRL: begin
            o_prdata[`FCL_CTRL_PROTECT_BIT] = r.protect;
            o_prdata[`FCL_CTRL_RESET_BIT] = r.dev_reset;
         end
         `FCL_REG_ADDR:   o_prdata = {10'h000, r.addr};
         `FCL_REG_DATA:   o_prdata = {16'h0000, r.data};
         `FCL_REG_STATUS: o_prdata = {31'h0000_0000, r.busy};
         `FCL_REG_RDATA:  o_prdata = {16'h0000, r.rdata};
         default:         o_prdata = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------------
   // Sequencer and pin timing.
   // ------------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (wr_acc) begin
         unique case (i_paddr)
            `FCL_REG_ADDR: next_r.addr = i_pwdata[21:0];
            `FCL_REG_DATA: next_r.data = i_pwdata[15:0];
            `FCL_REG_CTRL: begin
               // Arg bits overlap the pin controls, so GO writes keep them.
               if (!i_pwdata[`FCL_CTRL_GO_BIT]) begin
                  next_r.protect = i_pwdata[`FCL_CTRL_PROTECT_BIT];
                  next_r.dev_reset = i_pwdata[`FCL_CTRL_RESET_BIT];
               end else if (!r.busy) begin
                  next_r.busy = 1'b1;
                  next_r.phase = 4'd0;
                  next_r.op = i_pwdata[`FCL_CTRL_OP_LSB +: 8];
                  next_r.arg = i_pwdata[7:0];
                  next_r.page_left = i_pwdata[`FCL_CTRL_PAGE_LSB +: 5];
                  next_r.second = i_pwdata[`FCL_CTRL_SECOND_BIT];
                  next_r.state = i_pwdata[`FCL_CTRL_READ_BIT] ?
                                 FCL_READ : FCL_CMD;
               end
            end
            default: ;
         endcase
      end
      next_r.pin_cs_n = 1'b1;
      next_r.pin_we_n = 1'b1;
      next_r.pin_rd_n = 1'b1;
      next_r.pin_oe = 1'b0;
      if (r.state != FCL_IDLE) begin
         next_r.phase = r.phase + 4'd1;
         // Address stays on the block address for both cycles.  see R03
         next_r.pin_addr = r.addr;  // see R04
         next_r.pin_cs_n = 1'b0;
         // Strobes release together so data holds past either edge.
         if (r.state == FCL_READ) begin
            next_r.pin_rd_n = (r.phase == `FCL_PHASE_CYCLES);  // see R26
            if (r.phase == `FCL_SAMPLE_CYCLE) begin
               next_r.rdata = i_flash_dq;
            end
         end else begin
            next_r.pin_oe = 1'b1;
            next_r.pin_we_n = (r.phase == `FCL_PHASE_CYCLES);  // see R10
         end
         unique case (r.state)
            FCL_CMD: next_r.pin_dq = {8'h00, r.op};  // see R05 see R06 see R12
            FCL_ARG: next_r.pin_dq = r.second ? {8'h00, r.arg} : r.data;
            FCL_PAGE: next_r.pin_dq = r.data;
            FCL_CONF: next_r.pin_dq = {8'h00, r.arg};
            default: next_r.pin_dq = r.pin_dq;
         endcase
         if (r.phase == `FCL_PHASE_CYCLES) begin
            next_r.phase = 4'd0;
            next_r.pin_cs_n = 1'b1;
            next_r.pin_we_n = 1'b1;
            next_r.pin_rd_n = 1'b1;
            unique case (r.state)
               // Two-cycle ops: erase, chip erase, program, lock, config.
               FCL_CMD: begin
                  if (r.op == `FCL_CMD_PAGE_PROGRAM) begin
                     next_r.state = FCL_ARG;  // see R11
                     next_r.second = 1'b1;
                  end else if (r.op == `FCL_CMD_ERASE_SETUP ||
                               r.op == `FCL_CMD_CHIP_ERASE ||
                               r.op == `FCL_CMD_PROGRAM ||
                               r.op == `FCL_CMD_PROGRAM_ALT ||
                               r.op == `FCL_CMD_LOCK_SETUP) begin
                     next_r.state = FCL_ARG;  // see R07 see R08 see R09
                  end else begin
                     // Suspend and resume go out in software's order.  see R13
                     next_r.state = FCL_IDLE;
                     next_r.busy = 1'b0;
                  end
               end
               FCL_ARG: begin
                  if (r.op == `FCL_CMD_PAGE_PROGRAM) begin
                     next_r.state = FCL_PAGE;
                     next_r.busy = 1'b0;  // host supplies each pair next
                  end else begin
                     next_r.state = FCL_IDLE;  // see R14 see R15
                     next_r.busy = 1'b0;
                  end
               end
               FCL_PAGE: begin
                  next_r.busy = 1'b0;
                  next_r.page_left = r.page_left - 5'd1;
                  next_r.state = (r.page_left == 5'd0) ? FCL_CONF : FCL_PAGE;
               end
               FCL_CONF: begin
                  next_r.state = FCL_IDLE;
                  next_r.busy = 1'b0;
               end
               default: begin
                  next_r.state = FCL_IDLE;
                  next_r.busy = 1'b0;
               end
            endcase
         end
         // Page data and confirm cycles wait for software to refill data.
         if ((r.state == FCL_PAGE || r.state == FCL_CONF) && !r.busy &&
             r.phase == 4'd0) begin
            next_r.phase = 4'd0;
            next_r.pin_cs_n = 1'b1;
            next_r.pin_we_n = 1'b1;
            next_r.pin_oe = 1'b0;
            if (wr_acc && i_paddr == `FCL_REG_CTRL &&
                i_pwdata[`FCL_CTRL_GO_BIT]) begin
               next_r.busy = 1'b1;
               next_r.state = r.state;
               next_r.arg = i_pwdata[7:0];
               next_r.op = r.op;
               next_r.page_left = r.page_left;
               next_r.second = r.second;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '{state: FCL_IDLE, phase: 4'h0, busy: 1'b0, second: 1'b0,
                op: 8'h00, arg: 8'h00, page_left: 5'h00, addr: 22'h000000,
                data: 16'h0000, rdata: 16'h0000, protect: 1'b0,
                dev_reset: 1'b0, pin_addr: 22'h000000, pin_dq: 16'h0000,
                pin_oe: 1'b0, pin_cs_n: 1'b1, pin_we_n: 1'b1,
                pin_rd_n: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign o_flash_addr = r.pin_addr;
   assign o_flash_dq = r.pin_dq;
   assign o_flash_dq_oe = r.pin_oe;
   assign o_flash_die_select_n = r.pin_cs_n;
   assign o_flash_we_n = r.pin_we_n;
   assign o_flash_oe_n = r.pin_rd_n;
   assign o_flash_reset_n = r.dev_reset;  // see R16 see R20
   assign o_flash_protect_n = r.protect;  // see R22 see R23 see R24
endmodule
`default_nettype wire

// File: verification/fcl_host_props.sv
// Pin-level checks of the flash command host controller.
`timescale 1ns/1ns
`default_nettype none
module fcl_host_props (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic [21:0] o_flash_addr,
   input wire logic [15:0] o_flash_dq,
   input wire logic        o_flash_dq_oe,
   input wire logic        o_flash_die_select_n,
   input wire logic        o_flash_we_n,
   input wire logic        o_flash_oe_n
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   a_oe_we_apart: assert property (o_flash_oe_n || o_flash_we_n)
      else $error("output enable and write strobe low together");
   a_we_framed: assert property (!o_flash_we_n |->
      !o_flash_die_select_n && o_flash_dq_oe)
      else $error("write strobe outside a driven select");
   a_addr_held: assert property (!o_flash_die_select_n &&
      $past(!o_flash_die_select_n) |-> $stable(o_flash_addr))
      else $error("address moved within a cycle");
   a_data_held: assert property (!o_flash_we_n &&
      $past(!o_flash_we_n) |-> $stable(o_flash_dq))
      else $error("write data moved under the strobe");
   a_we_pulse: assert property ($fell(o_flash_we_n) |->
      (!o_flash_we_n)[*3] ##1 o_flash_we_n)
      else $error("write strobe width wrong");
   a_strobes_rise: assert property ($rose(o_flash_we_n) |->
      $rose(o_flash_die_select_n))
      else $error("write strobe ended apart from select");
   a_read_released: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
      else $error("data driven during a read");
   cover property ($fell(o_flash_we_n));
   cover property ($fell(o_flash_oe_n));
   cover property ($rose(o_flash_die_select_n));
endmodule
`default_nettype wire

// File: verification/fcl_flash_model.sv
// Behavioural flash die facing the host controller.
`timescale 1ns/1ns
`default_nettype none
module fcl_flash_model #(
   parameter logic [15:0] MAKER = 16'h0a5a, // Arbitrary value.
   parameter logic [15:0] PART  = 16'h0c3c  // Arbitrary value.
) (
   input  wire logic [21:0] i_addr,
   input  wire logic [15:0] i_dq,
   input  wire logic        i_cs_n,
   input  wire logic        i_we_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_rst_n,
   input  wire logic        i_wp,
   output logic      [15:0] o_dq
);
   logic [15:0] mem [int];
   logic [2:0]  lk [int];
   logic [7:0]  mode, pend, st;
   logic [15:0] rd, cfg;
   logic [2:0]  s;
   int          b, pc;
   int          kq[$];
   // One status word and one engine; every operation ends inside its own
   // write cycle, so nothing overlaps or queues.
   wire logic   wr = i_cs_n | i_we_n;
   function automatic logic [2:0] ls(input int k);
      return lk.exists(k) ? lk[k] : 3'b001;
   endfunction
   always @(negedge i_rst_n) begin
      lk.delete();
      pend = 8'h00;
      st = 8'h00;
      mode = 8'hff;
      cfg = 16'h0100;
      pc = 0;
   end
   always @(i_wp) begin
      foreach (lk[k]) begin
         if (i_wp && lk[k] == 3'b111) lk[k] = 3'b010;
         if (!i_wp && lk[k][1:0] == 2'b10) lk[k] = 3'b111;
      end
   end
   always @(posedge wr) begin
      b = int'(i_addr[21:15]);
      s = ls(b);
      if (pend == 8'h60) begin
         if (i_dq[7:0] == 8'h04) cfg = i_addr[15:0];
         else if (s[1:0] != 2'b11 || i_wp) begin
            case (i_dq[7:0])
               8'h01: s[0] = 1'b1;
               8'h2f: s = 3'b011;
               8'hd0: if (i_wp || !s[1]) s[0] = 1'b0;
               default: ;
            endcase
            lk[b] = {1'b0, s[1:0]};
         end
         pend = 8'h00;
      end else if (pend == 8'h40 || pend == 8'h10) begin
         if (s[0] || !i_rst_n) st[1] = 1'b1;
         else mem[int'(i_addr)] = i_dq;
         pend = 8'h00;
      end else if (pend == 8'h20 || pend == 8'h30) begin
         if (i_dq[7:0] == 8'hd0) begin
            if (!i_rst_n || (pend == 8'h20 && s[0])) st[5] = 1'b1;
            else foreach (mem[k])
               if ((pend == 8'h30 || (k >> 15) == b) &&
                   !(ls(k >> 15) & 3'b001)) kq.push_back(k);
            foreach (kq[i]) mem.delete(kq[i]);
            kq.delete();
         end
         pend = 8'h00;
      end else if (pend == 8'he8) begin
         pc = int'(i_dq) + 1;
         pend = 8'he9;
      end else if (pend == 8'he9) begin
         if (pc == 0) pend = 8'h00;
         else begin
            if (s[0] || !i_rst_n) st[1] = 1'b1;
            else mem[int'(i_addr)] = i_dq;
            pc = pc - 1;
         end
      end else if (i_dq[7:0] == 8'h50) st = 8'h00;
      else if (i_dq[7:0] inside {8'hb0, 8'hd0}) pend = 8'h00;
      else if (i_dq[7:0] inside {8'h60, 8'h40, 8'h10, 8'h20, 8'h30, 8'he8})
         pend = i_dq[7:0];
      else if (i_dq[7:0] inside {8'hff, 8'h90, 8'h98, 8'h70})
         mode = i_dq[7:0];
   end
   always @* begin
      if (mode == 8'h70) rd = {8'h00, st | 8'h80};
      else if (mode == 8'h98) rd = 16'h0051;
      else if (mode == 8'h90) begin
         if (i_addr[14:0] == 15'h0002)
            rd = {13'h0, ls(int'(i_addr[21:15]))} & 16'h0003;
         else if (i_addr[15:0] == 16'h0000) rd = MAKER;
         else if (i_addr[15:0] == 16'h0001) rd = PART;
         else if (i_addr[15:0] == 16'h0006) rd = cfg;
         else rd = 16'h0000;
      end else rd = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'hffff;
      o_dq = (!i_cs_n && !i_oe_n) ? rd : ~rd;
   end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Top-level bench for the flash command host controller.
`include "fcl_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [15:0] MAKER = 16'h0a5a;
   localparam logic [15:0] PART  = 16'h0c3c;
   localparam logic [21:0] BLK   = 22'h048000;
   logic        clk, rst_n, psel, penable, pwrite, pready, cs_n, we_n;
   logic        oe_n, frst_n, wp, dq_oe, slverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [21:0] faddr;
   logic [15:0] dq_out, dq_in, got;
   int          n_errors, tests_run;
   fcl_host DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(slverr), .o_flash_addr(faddr), .i_flash_dq(dq_in),
      .o_flash_dq(dq_out), .o_flash_dq_oe(dq_oe),
      .o_flash_die_select_n(cs_n), .o_flash_we_n(we_n),
      .o_flash_oe_n(oe_n), .o_flash_reset_n(frst_n),
      .o_flash_protect_n(wp));
   fcl_flash_model #(.MAKER(MAKER), .PART(PART)) u_flash (.i_addr(faddr),
      .i_dq(dq_out), .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
      .i_rst_n(frst_n), .i_wp(wp), .o_dq(dq_in));
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      if (slverr !== 1'b0) begin
         n_errors++;
         $display("mismatch pslverr expected 0 seen %b", slverr);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic op(input logic [21:0] a, input logic [15:0] d,
                     input logic [7:0] c, input logic [7:0] g);
      apb(1'b1, `FCL_REG_ADDR, {10'h000, a});
      apb(1'b1, `FCL_REG_DATA, {16'h0000, d});
      apb(1'b1, `FCL_REG_CTRL, {1'b1, 1'b0, g != 8'h00, 13'h0, c, g});
      do apb(1'b0, `FCL_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic ctl(input logic w);
      apb(1'b1, `FCL_REG_CTRL, {30'h0, w, 1'b1});
   endtask
   task automatic rchk(input string nm, input logic [21:0] a,
                       input logic [15:0] e);
      apb(1'b1, `FCL_REG_ADDR, {10'h000, a});
      apb(1'b1, `FCL_REG_CTRL, 32'hc0000000);
      do apb(1'b0, `FCL_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
      apb(1'b0, `FCL_REG_RDATA, 32'h0);
      got = q[15:0];
      tests_run++;
      if (got !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic t_ident;
      op(BLK, 16'h0, `FCL_CMD_READ_ID, 8'h00);
      rchk("maker", 22'h000000, MAKER);
      rchk("part", 22'h000001, PART);
      rchk("reset lock", BLK + 22'h2, 16'h0001);
      op(22'h000300, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_PART_CONFIG);
      op(BLK, 16'h0, `FCL_CMD_READ_ID, 8'h00);
      rchk("layout", 22'h000006, 16'h0300);
      op(BLK, 16'h0, `FCL_CMD_READ_QUERY, 8'h00);
      rchk("query", BLK, 16'h0051);
      $display("identifier test done");
   endtask
   task automatic t_lock;
      ctl(1'b1);
      op(BLK, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_CONFIRM);
      op(BLK, 16'h0, `FCL_CMD_READ_ID, 8'h00);
      rchk("unlock", BLK + 22'h2, 16'h0000);
      op(BLK, 16'h1234, `FCL_CMD_PROGRAM_ALT, 8'h00);
      op(BLK, 16'h0, `FCL_CMD_READ_ARRAY, 8'h00);
      rchk("array", BLK, 16'h1234);
      op(BLK, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_LOCK_DOWN);
      op(BLK, 16'h0, `FCL_CMD_READ_ID, 8'h00);
      rchk("lock down", BLK + 22'h2, 16'h0003);
      op(BLK, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_CONFIRM);
      rchk("down clear", BLK + 22'h2, 16'h0002);
      ctl(1'b0);
      rchk("relock", BLK + 22'h2, 16'h0003);
      op(BLK, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_CONFIRM);
      rchk("ignored", BLK + 22'h2, 16'h0003);
      ctl(1'b1);
      rchk("restore", BLK + 22'h2, 16'h0002);
      ctl(1'b0);
      op(BLK, 16'h5555, `FCL_CMD_PROGRAM, 8'h00);
      op(BLK, 16'h0, `FCL_CMD_READ_STATUS, 8'h00);
      rchk("refused", BLK, 16'h0082);
      op(BLK, 16'h0, `FCL_CMD_CLEAR_STATUS, 8'h00);
      rchk("cleared", BLK, 16'h0080);
      op(BLK, 16'h0, `FCL_CMD_SUSPEND, 8'h00);
      op(BLK, 16'h0, `FCL_CMD_CONFIRM, 8'h00);
      rchk("resumed", BLK, 16'h0080);
      $display("lock test done");
   endtask
   task automatic t_reset;
      apb(1'b1, `FCL_REG_CTRL, 32'h0000_0000);
      ctl(1'b0);
      op(BLK, 16'h0, `FCL_CMD_READ_ID, 8'h00);
      rchk("relocked", BLK + 22'h2, 16'h0001);
      $display("reset test done");
   endtask
   task automatic t_page;
      op(BLK, 16'h0, `FCL_CMD_LOCK_SETUP, `FCL_CMD_CONFIRM);
      apb(1'b1, `FCL_REG_ADDR, {10'h000, BLK});
      apb(1'b1, `FCL_REG_CTRL,
          {11'h400, 5'd1, `FCL_CMD_PAGE_PROGRAM, 8'h01});
      do apb(1'b0, `FCL_REG_STATUS, 32'h0); while (q[0] !== 1'b0);
      op(BLK, 16'h1111, 8'h00, 8'h00);
      op(BLK + 22'h1, 16'h2222, 8'h00, 8'h00);
      op(BLK, 16'h0, 8'h00, `FCL_CMD_CONFIRM);
      op(BLK, 16'h0, `FCL_CMD_READ_ARRAY, 8'h00);
      rchk("page first", BLK, 16'h1111);
      rchk("page second", BLK + 22'h1, 16'h2222);
      op(BLK, 16'h0, `FCL_CMD_ERASE_SETUP, `FCL_CMD_CONFIRM);
      rchk("erased", BLK + 22'h1, 16'hffff);
      op(BLK, 16'h3333, `FCL_CMD_PROGRAM, 8'h00);
      op(BLK, 16'h0, `FCL_CMD_CHIP_ERASE, `FCL_CMD_CONFIRM);
      rchk("chip erased", BLK, 16'hffff);
      $display("page test done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_errors = 0;
      tests_run = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      ctl(1'b0);
      t_ident();
      t_lock();
      t_reset();
      t_page();
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule
bind fcl_host fcl_host_props u_props (.i_core_clk, .i_rst_n,
   .o_flash_addr, .o_flash_dq, .o_flash_dq_oe, .o_flash_die_select_n,
   .o_flash_we_n, .o_flash_oe_n);
`default_nettype wire
